// file: shared/sag_pkg.sv
// Constants for the streaming address generator slots.
// Assumes a single CPU clock and register-move access from the .C unit.
package sag_pkg;
   localparam int SLOTS = 4;
   localparam int LEVELS = 6;
   localparam int FW = 32;
   localparam int REG_W = 512;
   // Register-move addresses; slot n config at base+2n, count at base+2n+1
   localparam logic [15:0] ADDR_FIRST = 16'h1004;
   localparam logic [15:0] ADDR_LAST = 16'h100b;
   // Configuration register layout
   localparam int ICNT_LSB = 0;
   localparam int TILE_A_LSB = 192;
   localparam int TILE_B_LSB = 224;
   localparam int DIM_LSB = 256;
   localparam int FLAGS_LSB = 448;
   localparam int STRIP_B_SEL_LSB = 51;
   localparam int STRIP_A_SEL_LSB = 48;
   localparam int FMT_LSB = 24;
   localparam int VECTOR_LENGTH_SELECT_LSB = 12;
   localparam logic [63:0] FLAGS_MASK = 64'h003f_0000_0700_7000;
   localparam logic [511:0] CFG_MASK = {FLAGS_MASK, 32'h0, {416{1'b1}}};
   // Count register layout
   localparam int CNT_LSB = 256;
   localparam int STRIP_A_CNT_LSB = 448;
   localparam int STRIP_B_CNT_LSB = 480;
   localparam int OFFSET_LSB = 0;
   localparam logic [511:0] CNT_MASK = {256'h0 - 256'h1, 64'h0, {192{1'b1}}};
   localparam logic [511:0] CFG_RESET = 512'h0;
   localparam logic [511:0] CNT_RESET = 512'h0;
   // Level width codes, per level 5..0, two bits each
   localparam logic [1:0] LV_OFF = 2'h0;
   localparam logic [1:0] LV_16 = 2'h1;
   localparam logic [1:0] LV_32 = 2'h2;
   localparam logic [11:0] FMT_000 = 12'h222;
   localparam logic [11:0] FMT_001 = 12'h225;
   localparam logic [11:0] FMT_010 = 12'h252;
   localparam logic [11:0] FMT_011 = 12'h255;
   localparam logic [11:0] FMT_SIX = 12'h555;
endpackage : sag_pkg

// file: logic/stream_address_generator.sv
// Four-slot streaming address generator state kept beside the CPU pipeline.
// Assumes requests come from logic on ref_clk; at most one of each kind per cycle.

// What this block does
// - Config is 512 bits: counts low, tiles, strides from 256, flags top 64.
// - Six 32-bit loop counts, level 0 innermost, level 5 outermost.
// - Levels 1-5 each have a signed 32-bit stride in elements.
// - Two 32-bit tile widths pair with their strip dimension selectors.
// - Flags: strip select b 53-51, a 50-48, fold format 26-24.
// - Fold format merges 16-bit count and stride pairs into 32-bit fields.
// - Lower level of a joined pair uses the combined, larger value.
// - Inactive levels behave as if their count were exactly one.
// - Formats 000-011 give three to five levels per the fold table.
// - Formats 110 and 111 give six 16-bit levels; 100, 101 reserved.
// - Count register upper half holds remaining counts and strip counts.
// - Lower half: current offset, saved offsets of levels 1-5, 255-192 reserved.
// - Each advancing access subtracts the vector length from the active count.
// - A level reaching zero steps the address by the next level's stride.
// - Opening a stream loads each level's effective count, one for an inactive level; strip counts come from the tile widths.
// - Functional register moves to an open stream's registers are refused.
// - Debugger register moves still reach the registers while open.
module stream_address_generator
   import sag_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic mv_valid,
   input wire logic mv_write,
   input wire logic mv_debug,
   input wire logic [15:0] mv_addr,
   input wire logic [sag_pkg::REG_W-1:0] mv_wdata,
   input wire logic open_valid,
   input wire logic [1:0] open_slot,
   input wire logic close_valid,
   input wire logic [1:0] close_slot,
   input wire logic adv_valid,
   input wire logic [1:0] adv_slot,
   output logic mv_ack,
   output logic mv_fault,
   output logic [sag_pkg::REG_W-1:0] mv_rdata,
   output logic [sag_pkg::SLOTS-1:0] stream_open,
   output logic [sag_pkg::SLOTS-1:0] stream_done,
   output logic offset_valid,
   output logic [31:0] elem_offset
);
   import sag_pkg::*;

   typedef struct packed {
      logic [SLOTS-1:0][REG_W-1:0] cfg;
      logic [SLOTS-1:0][REG_W-1:0] cnt;
      logic [SLOTS-1:0] open;
      logic [SLOTS-1:0] done;
      logic ack;
      logic fault;
      logic [REG_W-1:0] rdata;
      logic off_vld;
      logic [31:0] off;
   } state_t;

   state_t s_reg;
   state_t s_next;

   // Width code of one level under a fold format
   function automatic logic [1:0] level_kind(input logic [2:0] fmt, input int lvl);
      logic [11:0] tab;
      unique case (fmt)
         3'h1: tab = FMT_001;
         3'h2: tab = FMT_010;
         3'h3: tab = FMT_011;
         3'h6, 3'h7: tab = FMT_SIX;
         // reserved codes fall back to the plain three-level form
         default: tab = FMT_000;
      endcase
      return tab[2*lvl +: 2];
   endfunction : level_kind

   // Effective loop count of a level
   function automatic logic [31:0] eff_count(input logic [REG_W-1:0] c, input int lvl);
      logic [1:0] k;
      logic [31:0] f;
      k = level_kind(c[FLAGS_LSB+FMT_LSB +: 3], lvl);
      f = c[ICNT_LSB+FW*lvl +: FW];
      if (k == LV_OFF) return 32'h1;
      // 16-bit levels use the low half only
      if (k == LV_16) return {16'h0, f[15:0]};
      // joined level owns the whole field
      return f;
   endfunction : eff_count

   // Effective signed stride of levels 1..5
   function automatic logic [31:0] eff_dim(input logic [REG_W-1:0] c, input int lvl);
      logic [1:0] k;
      logic [31:0] f;
      k = level_kind(c[FLAGS_LSB+FMT_LSB +: 3], lvl);
      f = c[DIM_LSB+FW*(lvl-1) +: FW];
      if (k == LV_OFF) return 32'h0;
      if (k == LV_16) return {{16{f[15]}}, f[15:0]};
      return f;
   endfunction : eff_dim

   // Request handling; open wins over an advance on the same slot
   always_comb begin
      logic [15:0] idx;
      logic [1:0] sl;
      logic [REG_W-1:0] c;
      logic [REG_W-1:0] n;
      logic [31:0] elems;
      logic [31:0] rem0;
      logic [31:0] base;
      logic found;
      int lv;
      idx = mv_addr - ADDR_FIRST;
      sl = idx[2:1];
      c = '0;
      n = '0;
      elems = '0;
      rem0 = '0;
      base = '0;
      found = 1'b0;
      lv = 0;
      s_next = s_reg;
      s_next.ack = 1'b0;
      s_next.fault = 1'b0;
      s_next.rdata = '0;
      s_next.off_vld = 1'b0;

      // Register move port, answered one cycle later
      if (mv_valid) begin
         s_next.ack = 1'b1;
         if (mv_addr < ADDR_FIRST || mv_addr > ADDR_LAST) begin
            s_next.fault = 1'b1;
         end else if (s_reg.open[sl] && !mv_debug) begin
            s_next.fault = 1'b1;
         end else if (mv_write) begin
            // odd index selects the count register
            if (idx[0]) s_next.cnt[sl] = mv_wdata & CNT_MASK;
            else s_next.cfg[sl] = mv_wdata & CFG_MASK;
         end else begin
            s_next.rdata = idx[0] ? s_reg.cnt[sl] : s_reg.cfg[sl];
         end
      end

      if (close_valid) begin
         s_next.open[close_slot] = 1'b0;
      end

      // Stream open: counts loaded, offsets cleared
      if (open_valid) begin
         c = s_next.cfg[open_slot];
         n = '0;
         s_next.done[open_slot] = 1'b0;
         for (int l = 0; l < LEVELS; l++) begin
            n[CNT_LSB+FW*l +: FW] = eff_count(c, l);
            // an empty level means nothing to do
            if (eff_count(c, l) == 32'h0) s_next.done[open_slot] = 1'b1;
         end
         // strip counts start at the tile widths
         n[STRIP_A_CNT_LSB +: FW] = c[TILE_A_LSB +: FW];
         n[STRIP_B_CNT_LSB +: FW] = c[TILE_B_LSB +: FW];
         s_next.cnt[open_slot] = n;
         s_next.open[open_slot] = 1'b1;
      end

      // Advancing access on an open, unfinished stream
      if (adv_valid && s_reg.open[adv_slot] && !s_reg.done[adv_slot]
          && !(open_valid && open_slot == adv_slot)) begin
         c = s_reg.cfg[adv_slot];
         n = s_reg.cnt[adv_slot];
         s_next.off_vld = 1'b1;
         s_next.off = n[OFFSET_LSB +: FW];
         // vector length from its flag field
         elems = 32'h1 << c[FLAGS_LSB+VECTOR_LENGTH_SELECT_LSB +: 3];
         rem0 = n[CNT_LSB +: FW];
         // inner count drops by the vector length
         if (rem0 > elems) begin
            n[CNT_LSB +: FW] = rem0 - elems;
            n[OFFSET_LSB +: FW] = n[OFFSET_LSB +: FW] + elems;
         end else begin
            // Lowest outer level with iterations left takes the carry
            for (int l = 1; l < LEVELS; l++) begin
               if (!found && n[CNT_LSB+FW*l +: FW] > 32'h1) begin
                  found = 1'b1;
                  lv = l;
               end
            end
            if (found) begin
               n[CNT_LSB+FW*lv +: FW] = n[CNT_LSB+FW*lv +: FW] - 32'h1;
               // step by the next level's stride
               base = n[OFFSET_LSB+FW*lv +: FW] + eff_dim(c, lv);
               for (int l = 0; l < LEVELS; l++) begin
                  if (l < lv) n[CNT_LSB+FW*l +: FW] = eff_count(c, l);
                  if (l >= 1 && l <= lv) n[OFFSET_LSB+FW*l +: FW] = base;
               end
               n[OFFSET_LSB +: FW] = base;
            end else begin
               n[CNT_LSB +: FW] = 32'h0;
               s_next.done[adv_slot] = 1'b1;
            end
         end
         s_next.cnt[adv_slot] = n & CNT_MASK;
      end
   end

   // whole slot state held in one registered struct
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_reg <= '0;
      end else if (clk_en) begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from the state flops
   assign mv_ack = s_reg.ack;
   assign mv_fault = s_reg.fault;
   assign mv_rdata = s_reg.rdata;
   assign stream_open = s_reg.open;
   assign stream_done = s_reg.done;
   assign offset_valid = s_reg.off_vld;
   assign elem_offset = s_reg.off;

endmodule : stream_address_generator

// file: dv/sag_sva.sv
// Port checker for the stream address generator.
// Assumes one clock domain; bound to the design.
module sag_checker
   import sag_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic mv_valid,
   input wire logic mv_debug,
   input wire logic [15:0] mv_addr,
   input wire logic mv_ack,
   input wire logic mv_fault,
   input wire logic [511:0] mv_rdata,
   input wire logic open_valid,
   input wire logic [1:0] open_slot,
   input wire logic adv_valid,
   input wire logic [1:0] adv_slot,
   input wire logic [3:0] stream_open,
   input wire logic [3:0] stream_done,
   input wire logic offset_valid
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Taken requests; an open to the same slot beats an advance
   wire go = mv_valid & clk_en;
   wire [15:0] idx = mv_addr - ADDR_FIRST;
   wire in_map = (mv_addr >= ADDR_FIRST) && (mv_addr <= ADDR_LAST);
   wire adv_go = adv_valid & clk_en & ~(open_valid & open_slot == adv_slot);
   chk_ack_follows: assert property (go |=> mv_ack)
      else $error("move not acked");
   chk_ack_only: assert property (!go |=> !mv_ack)
      else $error("stray ack");
   chk_unmapped_fault: assert property (go && !in_map |=> mv_fault)
      else $error("unmapped move not faulted");
   chk_open_lock: assert property (go && in_map && !mv_debug && stream_open[idx[2:1]]
      |=> mv_fault && mv_rdata == '0) else $error("open slot not locked");
   chk_debug_pass: assert property (go && in_map && mv_debug |=> !mv_fault)
      else $error("debug move faulted");
   chk_open_sets: assert property (open_valid && clk_en |=> stream_open[$past(open_slot)])
      else $error("open not shown");
   chk_adv_answer: assert property (adv_go && stream_open[adv_slot] &&
      !stream_done[adv_slot] |=> offset_valid) else $error("advance not answered");
   chk_done_quiet: assert property (adv_valid && clk_en && stream_done[adv_slot]
      |=> !offset_valid) else $error("done slot advanced");
   cover property (mv_ack && mv_fault);
   cover property (offset_valid);
   cover property ($rose(stream_done[0]));
endmodule : sag_checker

bind stream_address_generator sag_checker chk_u (.ref_clk, .rst, .clk_en, .mv_valid,
   .mv_debug, .mv_addr, .mv_ack, .mv_fault, .mv_rdata, .open_valid, .open_slot,
   .adv_valid, .adv_slot, .stream_open, .stream_done, .offset_valid);

// file: dv/cpu_issue_model.sv
// Issue-side model: the pipeline sending moves, opens and advances.
// Assumes its tasks are called one at a time.
module cpu_issue_model (
   input wire logic ref_clk,
   input wire logic mv_ack,
   input wire logic mv_fault,
   input wire logic [511:0] mv_rdata,
   input wire logic offset_valid,
   input wire logic [31:0] elem_offset,
   output logic mv_valid,
   output logic mv_write,
   output logic mv_debug,
   output logic [15:0] mv_addr,
   output logic [511:0] mv_wdata,
   output logic open_valid,
   output logic [1:0] open_slot,
   output logic adv_valid,
   output logic [1:0] adv_slot
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle at time zero
   initial {mv_valid, mv_write, mv_debug, mv_addr, mv_wdata, open_valid, open_slot,
      adv_valid, adv_slot} = '0;
   // register move by address; idle lines flip so stale values never pass
   task automatic do_mv(input logic [15:0] a, input logic w, g, input logic [511:0] d,
         output logic ack, flt, output logic [511:0] q);
      @(posedge ref_clk);
      {mv_valid, mv_write, mv_debug, mv_addr, mv_wdata} <= {1'b1, w, g, a, d};
      @(posedge ref_clk);
      {mv_valid, mv_addr, mv_wdata} <= {1'b0, ~a, ~d};
      #1 {ack, flt, q} = {mv_ack, mv_fault, mv_rdata};
   endtask : do_mv
   task automatic do_open(input logic [1:0] s);
      @(posedge ref_clk);
      {open_valid, open_slot} <= {1'b1, s};
      @(posedge ref_clk);
      {open_valid, open_slot} <= {1'b0, ~s};
   endtask : do_open
   task automatic do_adv(input logic [1:0] s, output logic ov, output logic [31:0] off);
      @(posedge ref_clk);
      {adv_valid, adv_slot} <= {1'b1, s};
      @(posedge ref_clk);
      {adv_valid, adv_slot} <= {1'b0, ~s};
      #1 {ov, off} = {offset_valid, elem_offset};
   endtask : do_adv
endmodule : cpu_issue_model

// file: dv/stream_address_generator_tb.sv
// Self-checking bench for the stream address generator.
// Assumes the issue model is the only source of moves, opens and advances; the bench drives closes.
module stream_address_generator_tb
   import sag_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   logic close_valid = 1'b0;
   logic [1:0] close_slot = 2'h0;
   logic mv_valid, mv_write, mv_debug, open_valid, adv_valid, mv_ack, mv_fault, offset_valid;
   logic [1:0] open_slot, adv_slot;
   logic [15:0] mv_addr;
   logic [511:0] mv_wdata, mv_rdata, q;
   logic [3:0] stream_open, stream_done;
   logic [31:0] elem_offset, off;
   logic ack, flt;
   int n_errors = 0;
   int check_count = 0;
   // 25 MHz clock
   always #20 ref_clk = ~ref_clk;
   stream_address_generator dut_u (.ref_clk, .rst, .clk_en, .mv_valid, .mv_write, .mv_debug,
      .mv_addr, .mv_wdata, .open_valid, .open_slot, .close_valid, .close_slot, .adv_valid,
      .adv_slot, .mv_ack, .mv_fault, .mv_rdata, .stream_open, .stream_done, .offset_valid,
      .elem_offset);
   cpu_issue_model cpu_u (.ref_clk, .mv_ack, .mv_fault, .mv_rdata, .offset_valid, .elem_offset,
      .mv_valid, .mv_write, .mv_debug, .mv_addr, .mv_wdata, .open_valid, .open_slot,
      .adv_valid, .adv_slot);
   task automatic check(input string what, input logic [511:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s exp %h seen %h", what, exp, seen);
      end
   endtask : check
   function automatic logic [511:0] mkcfg(input logic [2:0] fmt, vl,
         input logic [191:0] cnt, input logic [63:0] dim);
      mkcfg = '0;
      mkcfg[191:0] = cnt;
      mkcfg[319:256] = dim;
      mkcfg[FLAGS_LSB+FMT_LSB +: 3] = fmt;
      mkcfg[FLAGS_LSB+VECTOR_LENGTH_SELECT_LSB +: 3] = vl;
   endfunction : mkcfg
   // Reset values, masked write-back, unmapped address
   task automatic t_regs();
      cpu_u.do_mv(16'h100a, 1'b0, 1'b0, '0, ack, flt, q);
      check("cfg3 reset", q, CFG_RESET);
      cpu_u.do_mv(16'h1004, 1'b1, 1'b0, '1, ack, flt, q);
      cpu_u.do_mv(16'h1005, 1'b1, 1'b0, '1, ack, flt, q);
      cpu_u.do_mv(16'h1004, 1'b0, 1'b0, '0, ack, flt, q);
      check("cfg mask", q, CFG_MASK);
      cpu_u.do_mv(16'h1005, 1'b0, 1'b0, '0, ack, flt, q);
      check("cnt mask", q, CNT_MASK);
      cpu_u.do_mv(16'h1003, 1'b0, 1'b0, '0, ack, flt, q);
      check("unmapped", {ack, flt}, 2'h3);
   endtask : t_regs
   // Six 16-bit levels: inner 4, outer 2, stride 10, two elements a step
   task automatic t_walk();
      logic [31:0] offs[4] = '{0, 2, 10, 12};
      logic [511:0] c;
      c = mkcfg(3'h6, 3'h1, {32'h1, 32'h1, 32'h1, 32'h1, 32'h2, 32'h4}, {32'h0, 32'ha});
      cpu_u.do_mv(16'h1004, 1'b1, 1'b0, c, ack, flt, q);
      cpu_u.do_open(2'h0);
      #1 check("opened", {stream_open[0], stream_done[0]}, 2'h2);
      foreach (offs[i]) begin
         cpu_u.do_adv(2'h0, ack, off);
         check("offset", {ack, off}, {1'b1, offs[i]});
      end
      check("done", stream_done[0], 1'b1);
      cpu_u.do_adv(2'h0, ack, off);
      check("quiet", ack, 1'b0);
      cpu_u.do_mv(16'h1004, 1'b0, 1'b0, '0, ack, flt, q);
      check("lock", {flt, q[510:0]}, {1'b1, 511'h0});
      cpu_u.do_mv(16'h1004, 1'b0, 1'b1, '0, ack, flt, q);
      check("debug", q, c);
   endtask : t_walk
   // Three-level fold; a reserved code must act the same
   // Debug write, since the slot may still be open from an earlier pass
   task automatic t_fmt(input logic [2:0] fmt);
      logic [31:0] offs[4] = '{0, 1, 100, 101};
      cpu_u.do_mv(16'h1006, 1'b1, 1'b1, mkcfg(fmt, 3'h0, {32'h0, 32'h1, 32'h0, 32'h2,
         32'h0, 32'h2}, {32'd100, 32'h0}), ack, flt, q);
      cpu_u.do_open(2'h1);
      foreach (offs[i]) begin
         cpu_u.do_adv(2'h1, ack, off);
         check("fold offset", {ack, off}, {1'b1, offs[i]});
      end
      check("fold done", stream_done[1], 1'b1);
   endtask : t_fmt
   // Frozen clock enable drops a move; close clears slot 0's open flag
   task automatic t_ctrl();
      @(posedge ref_clk);
      clk_en <= 1'b0;
      cpu_u.do_mv(16'h1004, 1'b0, 1'b1, '0, ack, flt, q);
      check("frozen ack", ack, 1'b0);
      @(posedge ref_clk);
      clk_en <= 1'b1;
      close_valid <= 1'b1;
      close_slot <= 2'h0;
      @(posedge ref_clk);
      close_valid <= 1'b0;
      @(posedge ref_clk);
      #1 check("closed", stream_open[0], 1'b0);
   endtask : t_ctrl
   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      t_regs();
      t_walk();
      t_ctrl();
      t_fmt(3'h0);
      t_fmt(3'h4);
      print_verdict();
   end
   // Watchdog: the run needs well under 200 cycles
   initial begin
      repeat (2000) @(posedge ref_clk);
      n_errors++;
      print_verdict();
   end
endmodule : stream_address_generator_tb
